// file: rtl/dram_sdram_timing_config.sv
// Overview of operation
// - Area 2 wait field gives column strobe or latency 1,1,2,3; default 3.
// - Area 0 first-cycle waits 0,1,2,3,4,6,8,10; wait input ignored for code 0.
// - Area 0 burst states per transfer 2,2,3,4,4,6,8,10; wait input always used.
// - Memory control is 16 bits, zero on power-on reset, kept otherwise.
// - DRAM precharge field sets row strobe gap: 1 or 2 cycles.
// - SDRAM precharge field sets gap from precharge to bank-active.
// - Row-to-column field gives 1 to 4 cycles in both modes.
// - Extended timing bit makes the card-side controller ignore row-to-column.
// - SDRAM write blocks bank-active for precharge plus write recovery 1 to 3.
// - DRAM refresh row strobe assert lasts 2 to 5 cycles.
// - SDRAM auto-refresh blocks bank-active for precharge plus refresh-assert.
// - Bits 7 and 5 ignore writes; bit 7 reads zero.
// - Burst enable gives DRAM page bursts; SDRAM always bursts.
// - DRAM multiplex codes select row start A9, A10, A11, A12.
// - SDRAM multiplex codes select row start A9, A10, A11, A9.
// - Refresh mode 0 refreshes periodically ending cycles; mode 1 self-refreshes.
// - EDO bit moves DRAM read sampling to rising edge, delays row negation.
`timescale 1ns/1ps
`default_nettype none

module dram_sdram_timing_config (
  // Clock and power-on reset
  input  wire logic                                clk_in,
  input  wire logic                                reset_in,
  // Register port
  input  wire logic [7:0]                          reg_addr_in,
  input  wire logic [15:0]                         reg_wdata_in,
  input  wire logic                                reg_write_in,
  input  wire logic                                reg_read_in,
  output logic      [15:0]                         reg_rdata_out,
  // Memory type and bus events
  input  wire logic                                sdram_mode_in,
  input  wire logic                                row_negate_in,
  input  wire logic                                precharge_in,
  input  wire logic                                write_end_in,
  input  wire logic                                auto_refresh_in,
  input  wire logic                                refresh_request_in,
  input  wire logic                                bus_cycle_active_in,
  // Area 0 access
  input  wire logic                                area0_first_in,
  input  wire logic                                area0_beat_in,
  input  wire logic                                wait_in,
  output logic                                     area0_ready_out,
  // Timing and control outputs
  output dram_timing_pkg::timing_type              timing_out,
  output logic                                     activate_allowed_out,
  output logic                                     refresh_issue_out,
  output logic                                     end_cycle_out,
  output logic                                     refresh_row_strobe_out,
  output logic                                     self_refresh_out,
  output logic                                     edo_rising_sample_out,
  output logic                                     row_negate_delay_out
);

  dram_timing_pkg::mem_ctrl_type       mem_ctrl_q;
  logic [15:0]                         wait_ctrl_q;
  logic                                extend_q;
  logic [15:0]                         rdata_q;
  logic [dram_timing_pkg::GAP_W-1:0]   gap_q;
  logic [dram_timing_pkg::GAP_W-1:0]   ras_q;
  logic [dram_timing_pkg::WAIT_W-1:0]  wait_cnt_q;
  logic                                wait_honour_q;
  logic                                self_refresh_q;
  logic                                refresh_issue_q;
  dram_timing_pkg::timing_type         timing_d;
  logic [1:0]                          a2_code;
  logic [2:0]                          a0_code;
  logic                                refresh_on;
  logic [dram_timing_pkg::GAP_W-1:0]   tpc_n;

  assign a2_code = wait_ctrl_q[dram_timing_pkg::AREA2_WAIT_LSB +: 2];
  assign a0_code = wait_ctrl_q[dram_timing_pkg::AREA0_WAIT_LSB +: 3];
  assign refresh_on = mem_ctrl_q.refresh_enable_bit;

  // Field decode
  always_comb
  begin
    timing_d = '0;
    unique case (a2_code)
      2'h0, 2'h1: timing_d.column_cycles = 2'h1;
      2'h2:       timing_d.column_cycles = 2'h2;
      2'h3:       timing_d.column_cycles = 2'h3;
    endcase
    timing_d.first_wait_pin_enable = (a0_code != 3'h0);
    unique case (a0_code)
      3'h0:
      begin
        timing_d.first_wait_states = 4'h0;
        timing_d.burst_states = 4'h2;
      end
      3'h1:
      begin
        timing_d.first_wait_states = 4'h1;
        timing_d.burst_states = 4'h2;
      end
      3'h2:
      begin
        timing_d.first_wait_states = 4'h2;
        timing_d.burst_states = 4'h3;
      end
      3'h3:
      begin
        timing_d.first_wait_states = 4'h3;
        timing_d.burst_states = 4'h4;
      end
      3'h4:
      begin
        timing_d.first_wait_states = 4'h4;
        timing_d.burst_states = 4'h4;
      end
      3'h5:
      begin
        timing_d.first_wait_states = 4'h6;
        timing_d.burst_states = 4'h6;
      end
      3'h6:
      begin
        timing_d.first_wait_states = 4'h8;
        timing_d.burst_states = 4'h8;
      end
      3'h7:
      begin
        timing_d.first_wait_states = 4'ha;
        timing_d.burst_states = 4'ha;
      end
    endcase
    // Reserved precharge codes run at the longer gap
    timing_d.precharge_cycles = mem_ctrl_q.precharge[1] ? 2'h2
                                : {1'b0, 1'b1} + {1'b0, mem_ctrl_q.precharge[0]};
    timing_d.row_to_column_cycles = {1'b0, mem_ctrl_q.row_to_column_delay} + 3'h1;
    timing_d.row_to_column_apply = !extend_q;
    timing_d.write_recovery_cycles = (mem_ctrl_q.write_recovery_delay == 2'h3) ? 2'h3
                                     : mem_ctrl_q.write_recovery_delay + 2'h1;
    timing_d.refresh_assert_cycles = {1'b0, mem_ctrl_q.refresh_assert_cycles} + 3'h2;
    timing_d.burst_active = sdram_mode_in | mem_ctrl_q.burst_enable_bit;
    unique case (mem_ctrl_q.address_multiplex_select)
      2'h0: timing_d.row_start_bit = dram_timing_pkg::ROW_A9;
      2'h1: timing_d.row_start_bit = dram_timing_pkg::ROW_A10;
      2'h2: timing_d.row_start_bit = dram_timing_pkg::ROW_A11;
      2'h3: timing_d.row_start_bit = sdram_mode_in ? dram_timing_pkg::ROW_A9
                                     : dram_timing_pkg::ROW_A12;
    endcase
  end

  assign timing_out = timing_d;
  assign tpc_n = {2'b00, timing_d.precharge_cycles};
  assign edo_rising_sample_out = mem_ctrl_q.extended_out_sampling & !sdram_mode_in;
  assign row_negate_delay_out = mem_ctrl_q.extended_out_sampling & !sdram_mode_in;

  // Register writes; only power-on reset loads their reset values
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      mem_ctrl_q <= dram_timing_pkg::MEM_CTRL_RESET;
      wait_ctrl_q <= dram_timing_pkg::WAIT_CTRL_RESET;
      extend_q <= dram_timing_pkg::EXTEND_RESET;
    end
    else if (reg_write_in)
    begin
      if (reg_addr_in == dram_timing_pkg::MEM_CTRL_ADDR)
      begin
        mem_ctrl_q <= reg_wdata_in & dram_timing_pkg::MEM_CTRL_WMASK;
      end
      if (reg_addr_in == dram_timing_pkg::WAIT_CTRL_ADDR)
      begin
        wait_ctrl_q <= reg_wdata_in;
      end
      if (reg_addr_in == dram_timing_pkg::BUS_CTRL3_ADDR)
      begin
        extend_q <= reg_wdata_in[dram_timing_pkg::EXTEND_BIT];
      end
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      rdata_q <= 16'h0000;
    end
    else if (reg_read_in)
    begin
      unique case (reg_addr_in)
        dram_timing_pkg::MEM_CTRL_ADDR:  rdata_q <= mem_ctrl_q;
        dram_timing_pkg::WAIT_CTRL_ADDR: rdata_q <= wait_ctrl_q;
        dram_timing_pkg::BUS_CTRL3_ADDR: rdata_q <= {15'h0000, extend_q};
        dram_timing_pkg::STATUS_ADDR:    rdata_q <= {12'h000, !area0_ready_out,
                                                     refresh_row_strobe_out,
                                                     !activate_allowed_out, self_refresh_q};
        default:                         rdata_q <= 16'h0000;
      endcase
    end
    else
    begin
      rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata_out = rdata_q;

  // Bank-active / row strobe gap counter
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      gap_q <= '0;
    end
    else if (sdram_mode_in && auto_refresh_in)
    begin
      gap_q <= tpc_n + {1'b0, timing_d.refresh_assert_cycles};
    end
    else if (sdram_mode_in && write_end_in)
    begin
      gap_q <= tpc_n + {2'b00, timing_d.write_recovery_cycles};
    end
    else if ((sdram_mode_in && precharge_in) || (!sdram_mode_in && row_negate_in))
    begin
      gap_q <= tpc_n;
    end
    else if (gap_q != '0)
    begin
      gap_q <= gap_q - 1'b1;
    end
  end

  assign activate_allowed_out = (gap_q == '0);

  // Refresh control
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      self_refresh_q <= 1'b0;
      refresh_issue_q <= 1'b0;
    end
    else
    begin
      refresh_issue_q <= refresh_on && !mem_ctrl_q.refresh_mode_bit
                         && refresh_request_in && !self_refresh_q;
      if (!refresh_on || !mem_ctrl_q.refresh_mode_bit)
      begin
        self_refresh_q <= 1'b0;
      end
      else if (!bus_cycle_active_in)
      begin
        self_refresh_q <= 1'b1;
      end
    end
  end

  assign refresh_issue_out = refresh_issue_q;
  assign end_cycle_out = refresh_issue_q & bus_cycle_active_in;
  assign self_refresh_out = self_refresh_q;

  // Row strobe hold during DRAM refresh
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      ras_q <= '0;
    end
    else if (refresh_issue_q && !sdram_mode_in)
    begin
      ras_q <= {1'b0, timing_d.refresh_assert_cycles};
    end
    else if (ras_q != '0)
    begin
      ras_q <= ras_q - 1'b1;
    end
  end

  assign refresh_row_strobe_out = (ras_q != '0);

  // Area 0 wait counter
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      wait_cnt_q <= '0;
      wait_honour_q <= 1'b0;
    end
    else if (area0_first_in)
    begin
      wait_cnt_q <= timing_d.first_wait_states;
      wait_honour_q <= timing_d.first_wait_pin_enable;
    end
    else if (area0_beat_in)
    begin
      wait_cnt_q <= timing_d.burst_states - 4'h1;
      wait_honour_q <= 1'b1;
    end
    else if (wait_cnt_q != '0)
    begin
      wait_cnt_q <= wait_cnt_q - 1'b1;
    end
  end

  assign area0_ready_out = (wait_cnt_q == '0) && !(wait_honour_q && wait_in);

  sequence seq_sdram_write;
    sdram_mode_in && write_end_in && !auto_refresh_in;
  endsequence

  sequence seq_gap_blocked;
    !activate_allowed_out;
  endsequence

  AST_BIT7_ZERO: assert property (@(posedge clk_in) disable iff (reset_in)
    !mem_ctrl_q.rsv7 && !mem_ctrl_q.rsv5)
    else $error("reserved memory control bit set");

  AST_RESET_CLEAR: assert property (@(posedge clk_in)
    $past(reset_in) |-> mem_ctrl_q == 16'h0000)
    else $error("memory control not cleared by reset");

  AST_WRITE_GAP: assert property (@(posedge clk_in) disable iff (reset_in)
    seq_sdram_write ##1 1'b1 |-> gap_q == tpc_n + {2'b00, timing_d.write_recovery_cycles})
    else $error("write recovery gap wrong");

  AST_GAP_HOLDS: assert property (@(posedge clk_in) disable iff (reset_in)
    (!sdram_mode_in && row_negate_in && !auto_refresh_in && !write_end_in)
      |=> seq_gap_blocked)
    else $error("row strobe allowed too early");

  AST_GAP_ENDS: assert property (@(posedge clk_in) disable iff (reset_in)
    (sdram_mode_in && auto_refresh_in) |-> ##[1:8] activate_allowed_out
      or ##[1:8] (auto_refresh_in || write_end_in || precharge_in || row_negate_in))
    else $error("refresh gap never ends");

  AST_FIRST_WAIT: assert property (@(posedge clk_in) disable iff (reset_in)
    (area0_first_in && a0_code == 3'h7) |=> wait_cnt_q == 4'ha)
    else $error("area 0 first wait count wrong");

  AST_NO_WAIT_PIN: assert property (@(posedge clk_in) disable iff (reset_in)
    (area0_first_in && a0_code == 3'h0 && !area0_beat_in) |=> area0_ready_out)
    else $error("wait input honoured for code zero");

  AST_BURST_SDRAM: assert property (@(posedge clk_in) disable iff (reset_in)
    sdram_mode_in |-> timing_out.burst_active)
    else $error("sdram burst disabled");

  AST_SELF_NO_REFRESH: assert property (@(posedge clk_in) disable iff (reset_in)
    self_refresh_q |=> !refresh_issue_q)
    else $error("refresh issued in self-refresh");

  AST_CAS_DEFAULT: assert property (@(posedge clk_in) disable iff (reset_in)
    (a2_code == 2'h3) |-> timing_out.column_cycles == 2'h3)
    else $error("column latency code 3 wrong");

  AST_RAS_REFRESH: assert property (@(posedge clk_in) disable iff (reset_in)
    (refresh_issue_q && !sdram_mode_in && mem_ctrl_q.refresh_assert_cycles == 2'h0)
      |=> refresh_row_strobe_out [*2] ##1 !refresh_row_strobe_out
      or ##[1:3] refresh_issue_q)
    else $error("refresh row strobe length wrong");

endmodule // dram_sdram_timing_config

`default_nettype wire

// file: rtl/dram_timing_pkg.sv
package dram_timing_pkg;

  // Register byte addresses; each is the register index times four
  localparam logic [7:0] MEM_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] WAIT_CTRL_ADDR  = 8'h04;
  localparam logic [7:0] BUS_CTRL3_ADDR  = 8'h08;
  localparam logic [7:0] STATUS_ADDR     = 8'h0c;

  // Memory control layout
  typedef struct packed {
    logic [1:0] precharge;
    logic [1:0] row_to_column_delay;
    logic [1:0] write_recovery_delay;
    logic [1:0] refresh_assert_cycles;
    logic       rsv7;
    logic       burst_enable_bit;
    logic       rsv5;
    logic [1:0] address_multiplex_select;
    logic       refresh_enable_bit;
    logic       refresh_mode_bit;
    logic       extended_out_sampling;
  } mem_ctrl_type;

  localparam logic [15:0] MEM_CTRL_RESET  = 16'h0000;
  localparam logic [15:0] MEM_CTRL_WMASK  = 16'hff5f;
  localparam logic [15:0] WAIT_CTRL_RESET = 16'hffff;
  localparam int          AREA2_WAIT_LSB  = 3;
  localparam int          AREA0_WAIT_LSB  = 0;
  localparam int          EXTEND_BIT      = 0;
  localparam logic        EXTEND_RESET    = 1'b0;

  localparam int          GAP_W           = 4;
  localparam int          WAIT_W          = 4;

  // Decoded timing bundle
  typedef struct packed {
    logic [1:0]        column_cycles;
    logic [WAIT_W-1:0] first_wait_states;
    logic              first_wait_pin_enable;
    logic [WAIT_W-1:0] burst_states;
    logic [1:0]        precharge_cycles;
    logic [2:0]        row_to_column_cycles;
    logic [1:0]        write_recovery_cycles;
    logic [2:0]        refresh_assert_cycles;
    logic [3:0]        row_start_bit;
    logic              burst_active;
    logic              row_to_column_apply;
  } timing_type;

  localparam logic [3:0] ROW_A9  = 4'h9;
  localparam logic [3:0] ROW_A10 = 4'ha;
  localparam logic [3:0] ROW_A11 = 4'hb;
  localparam logic [3:0] ROW_A12 = 4'hc;

endpackage

// file: tb/mem_partner.sv
`timescale 1ns/1ps
`default_nettype none

module mem_partner (
  // Clock
  input  wire logic       clk_in,
  // Events: 0 row negate, 1 precharge, 2 write end, 3 auto refresh
  output logic      [3:0] event_out,
  // Wait line, high while the memory is slow
  output logic            wait_out
);
  initial
  begin
    event_out = 4'h0;
    wait_out  = 1'b0;
  end

  // One-cycle event, returns just after the edge that takes it
  task automatic pulse(input int kind);
    @(posedge clk_in);
    event_out <= 4'h1 << kind;
    @(posedge clk_in);
    event_out <= 4'h0;
    #1;
  endtask

  // Slow answer: hold or release the wait line
  task automatic set_wait(input logic v);
    @(posedge clk_in);
    wait_out <= v;
    #1;
  endtask
endmodule // mem_partner

`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_top;
  logic                        clk_in, reset_in, wr, rd, sdram, req, busy, first, beat;
  logic                        wait_l, ready, act, issue, endc, strobe, selfr, edo, rdly;
  logic [7:0]                  addr;
  logic [15:0]                 wdata, rdata, v;
  logic [3:0]                  ev;
  dram_timing_pkg::timing_type tm;
  int                          error_cnt, cmp_count, n;
  logic [3:0] fw [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'ha};
  logic [3:0] bs [8] = '{4'h2, 4'h2, 4'h3, 4'h4, 4'h4, 4'h6, 4'h8, 4'ha};
  logic [1:0] cc [4] = '{2'h1, 2'h1, 2'h2, 2'h3};
  logic [1:0] pc [4] = '{2'h1, 2'h2, 2'h2, 2'h2};
  logic [1:0] wrc [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
  logic [3:0] rsd [4] = '{4'h9, 4'ha, 4'hb, 4'hc};
  logic [3:0] rss [4] = '{4'h9, 4'ha, 4'hb, 4'h9};

  dram_sdram_timing_config uut (
    .clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata), .sdram_mode_in(sdram),
    .row_negate_in(ev[0]), .precharge_in(ev[1]), .write_end_in(ev[2]),
    .auto_refresh_in(ev[3]), .refresh_request_in(req), .bus_cycle_active_in(busy),
    .area0_first_in(first), .area0_beat_in(beat), .wait_in(wait_l),
    .area0_ready_out(ready), .timing_out(tm), .activate_allowed_out(act),
    .refresh_issue_out(issue), .end_cycle_out(endc), .refresh_row_strobe_out(strobe),
    .self_refresh_out(selfr), .edo_rising_sample_out(edo), .row_negate_delay_out(rdly));

  mem_partner mem (.clk_in(clk_in), .event_out(ev), .wait_out(wait_l));

  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic summarize();
    $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return ready;
      1: return act;
      2: return !strobe;
      3: return selfr;
      default: return !selfr;
    endcase
  endfunction

  // Edges until the watched level shows; negative exp only waits
  task automatic count_to(input int s, input int exp);
    n = 0;
    while (sig(s) !== 1'b1 && n < 60)
    begin
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n >= 60)
    begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, n, exp);
      summarize();
    end
    else if (exp >= 0)
      `CHK(n, exp)
  endtask

  task automatic start_a0(input logic is_first);
    @(posedge clk_in);
    first <= is_first;
    beat  <= !is_first;
    @(posedge clk_in);
    first <= 1'b0;
    beat  <= 1'b0;
    #1;
  endtask

  task automatic request();
    @(posedge clk_in);
    req <= 1'b1;
    @(posedge clk_in);
    req <= 1'b0;
    #1;
  endtask

  task automatic test_regs();
    rd_reg(8'h00, v);
    `CHK(v, 16'h0000)
    rd_reg(8'h04, v);
    `CHK(v, 16'hffff)
    `CHK(tm.column_cycles, 2'h3)
    `CHK(tm.row_to_column_apply, 1'b1)
    wr_reg(8'h00, 16'hffff);
    rd_reg(8'h00, v);
    `CHK(v, 16'hff5f)
    rd_reg(8'h10, v);
    `CHK(v, 16'h0000)
    wr_reg(8'h08, 16'h0001);
    `CHK(tm.row_to_column_apply, 1'b0)
    wr_reg(8'h08, 16'h0000);
    `CHK(tm.row_to_column_apply, 1'b1)
    $display("regs test done");
  endtask

  task automatic test_waits();
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(8'h04, 16'hffe0 | 16'(c) | (16'(c & 3) << 3));
      `CHK(tm.column_cycles, cc[c & 3])
      `CHK(tm.first_wait_states, fw[c])
      `CHK(tm.first_wait_pin_enable, 1'(c != 0))
      `CHK(tm.burst_states, bs[c])
    end
    wr_reg(8'h04, 16'hffff);
    start_a0(1'b1);
    count_to(0, 10);
    wr_reg(8'h04, 16'hfffd);
    start_a0(1'b0);
    count_to(0, 5);
    mem.set_wait(1'b1);
    wr_reg(8'h04, 16'hfff8);
    start_a0(1'b1);
    count_to(0, 0);
    start_a0(1'b0);
    repeat (3) @(posedge clk_in);
    #1;
    `CHK(ready, 1'b0)
    mem.set_wait(1'b0);
    count_to(0, 0);
    $display("waits test done");
  endtask

  task automatic test_decode();
    logic [1:0] c2;
    for (int m = 0; m < 2; m++)
      for (int c = 0; c < 4; c++)
      begin
        c2 = 2'(c);
        @(posedge clk_in);
        sdram <= 1'(m);
        wr_reg(8'h00, {c2, c2, c2, c2, 1'b0, c2[0], 1'b0, c2, 2'b00, c2[0]});
        `CHK(tm.precharge_cycles, pc[c])
        `CHK(tm.row_to_column_cycles, 3'(c + 1))
        `CHK(tm.write_recovery_cycles, wrc[c])
        `CHK(tm.refresh_assert_cycles, 3'(c + 2))
        `CHK(tm.row_start_bit, (m == 1) ? rss[c] : rsd[c])
        `CHK(tm.burst_active, 1'((m == 1) || c2[0]))
        `CHK(edo, 1'(c2[0] && m == 0))
        `CHK(rdly, 1'(c2[0] && m == 0))
      end
    $display("decode test done");
  endtask

  task automatic gap_case(input logic m, input logic [15:0] d, input int k, input int exp);
    @(posedge clk_in);
    sdram <= m;
    wr_reg(8'h00, d);
    mem.pulse(k);
    count_to(1, exp);
  endtask

  task automatic test_gap();
    gap_case(1'b0, 16'h0000, 0, 1);
    gap_case(1'b0, 16'h4000, 0, 2);
    gap_case(1'b0, 16'h4000, 1, 0);
    gap_case(1'b1, 16'h4000, 1, 2);
    gap_case(1'b1, 16'h4800, 2, 5);
    gap_case(1'b1, 16'h0300, 3, 6);
    $display("gap test done");
  endtask

  task automatic test_refresh();
    @(posedge clk_in);
    sdram <= 1'b0;
    busy  <= 1'b1;
    wr_reg(8'h00, 16'h4000);
    wr_reg(8'h00, 16'h4004);
    request();
    `CHK(issue, 1'b1)
    `CHK(endc, 1'b1)
    @(posedge clk_in);
    #1;
    `CHK(strobe, 1'b1)
    `CHK(issue, 1'b0)
    count_to(2, 2);
    @(posedge clk_in);
    busy <= 1'b0;
    wr_reg(8'h00, 16'h4006);
    count_to(3, -1);
    rd_reg(8'h0c, v);
    `CHK(v, 16'h0001)
    request();
    `CHK(issue, 1'b0)
    wr_reg(8'h00, 16'h4004);
    count_to(4, -1);
    $display("refresh test done");
  endtask

  initial
  begin
    reset_in = 1'b1;
    addr = 8'h00;
    wdata = 16'h0000;
    {wr, rd, sdram, req, busy, first, beat} = 7'h00;
    repeat (8) @(posedge clk_in);
    reset_in <= 1'b0;
    test_regs();
    test_waits();
    test_decode();
    test_gap();
    test_refresh();
    summarize();
  end
endmodule // tb_top

`default_nettype wire
